/* File: rtl/i2c_rx10_params.svh */
// Constants for the ten-bit address I2C target receiver
`ifndef I2C_RX10_PARAMS_SVH
`define I2C_RX10_PARAMS_SVH

// Event vector positions carried from the link domain to the system domain
`define EV_START 0
`define EV_STOP 1
`define EV_HI_MATCH 2
`define EV_LO_MATCH 3
`define EV_MISS 4
`define EV_DATA 5
`define EV_ACK_DONE 6
`define EV_NACK 7
`define EV_HOLD 8
`define EV_NUM 9

// Bit counter value on the rising edge that completes a byte (eighth clock)
`define LAST_BIT 4'h7
// Bit counter value after the seventh data clock
`define WAIT_BIT 4'h7
`define BIT_CNT_RESET 4'h0

// Position of the direction bit within an address byte
`define DIR_BIT 0

// Reset values
`define BYTE_RESET 8'h00
`define CNT_ZERO 8'h00

// Acknowledge sequencing steps inside an acknowledge slot
`define ACK_WAIT 2'h0
`define ACK_DRIVE 2'h1
`define ACK_PULSE 2'h2

`endif

/* File: rtl/i2c_rx10_pkg.sv */
// Types shared by the ten-bit address I2C target receiver
package i2c_rx10_pkg;

  typedef enum logic [6:0] {
    L_IDLE     = 7'h01,
    L_HI       = 7'h02,
    L_HI_ACK   = 7'h04,
    L_LO       = 7'h08,
    L_LO_ACK   = 7'h10,
    L_DATA     = 7'h20,
    L_DATA_ACK = 7'h40
  } link_state_e;

  typedef struct packed {
    logic shared_irq_flag;
    logic nack_flag;
    logic count_reached_flag;
    logic write_received_flag;
    logic addr_match_flag;
    logic stop_seen_flag;
    logic start_seen_flag;
  } flags_s;

  typedef struct packed {
    logic start_irq_enable;
    logic addr_hold_irq_enable;
    logic ack_hold_irq_enable;
    logic write_hold_irq_enable;
    logic ack_value;
    logic count_end_ack_value;
  } ctrl_s;

endpackage : i2c_rx10_pkg

/* File: rtl/event_cross.sv */
// Toggle-based crossing of a vector of one-cycle events into another clock domain
`timescale 1ns/1ps
module event_cross #(
  parameter int N = 9
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic [N-1:0] src_pulse,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic [N-1:0] dst_pulse
);

  logic [N-1:0] tgl_r;
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] last_r;

  // Events closer than a few destination cycles can be lost; the link spaces them far apart
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tgl_r <= '0;
    end else begin
      tgl_r <= tgl_r ^ src_pulse;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= tgl_r;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign dst_pulse = sync_r ^ last_r;

  a_toggle_flip: assert property (@(posedge src_clk) disable iff (src_rst)
    (src_pulse != '0) |=> (tgl_r == ($past(tgl_r) ^ $past(src_pulse))))
    else $error("event toggle did not flip");

endmodule : event_cross

/* File: rtl/i2c_rx10_target.sv */
// Ten-bit address I2C target receiver: link protocol engine and system-side status
//
// Contract
// - Compare seven upper high-address bits, both registers
// - Compare all eight low-address bits, both registers
// - Target active only after both bytes match
// - Start sets start flag, optionally shared irq
// - High match captures byte; mismatch goes idle
// - Address hold enable stretches clock after match
// - Drive chosen ack; release SCL when cleared
// - Pending error forces address NACK, then idle
// - Low match: active, flag, capture, ack
// - Ack hold enable stretches after each ack, except the ack of a read-request high byte (goes idle)
// - Stop instead of data: flag, idle
// - Unread buffer stretches after seventh data clock
// - Eighth clock: D/A, write flag, buffer load
// - Write hold enable stretches before data ack
// - Zero count: count-end ack; else ack, decrement
// - Zero count after data ack sets flag
// - NACK on data: NACK flag, go idle
`timescale 1ns/1ps
`include "i2c_rx10_params.svh"
module i2c_rx10_target
  import i2c_rx10_pkg::*;
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic LCLK,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic [7:0] HIGH_ADDR_MATCH_A,
  input wire logic [7:0] HIGH_ADDR_MATCH_B,
  input wire logic [7:0] LOW_ADDR_MATCH_A,
  input wire logic [7:0] LOW_ADDR_MATCH_B,
  input wire ctrl_s CTRL,
  input wire logic RX_OVERFLOW_ERR,
  input wire logic TX_UNDERFLOW_ERR,
  input wire logic CLOCK_STRETCH_CLR,
  input wire logic RX_READ,
  input wire flags_s FLAG_CLR,
  input wire logic BYTE_COUNT_LOAD,
  input wire logic [7:0] BYTE_COUNT_IN,
  output flags_s FLAGS,
  output logic CLOCK_STRETCH_BIT,
  output logic TARGET_ACTIVE,
  output logic RX_BUFFER_FULL,
  output logic [7:0] RX_BUFFER,
  output logic [7:0] HIGH_ADDR_CAPTURE,
  output logic [7:0] LOW_ADDR_CAPTURE,
  output logic [7:0] BYTE_COUNTER,
  output logic DIRECTION,
  output logic DATA_NOT_ADDR
);

  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] ma,
                                    input logic [7:0] mb, input logic whole);
    logic [7:0] keep;
    keep = whole ? 8'hff : 8'hfe;
    addr_hit = ((rx & keep) == (ma & keep)) || ((rx & keep) == (mb & keep));
  endfunction : addr_hit

  localparam int CFG_W = 42;

  // System-domain state
  flags_s flags_r, flags_nxt, flag_set;
  logic stretch_r, rx_full_r, active_r, dir_r, dna_r;
  logic [7:0] rx_buf_r, hi_cap_r, lo_cap_r, cnt_r, cnt_nxt;
  logic [`EV_NUM-1:0] ev_m;
  wire cnt_zero = (cnt_r == `CNT_ZERO);
  wire err_any = RX_OVERFLOW_ERR | TX_UNDERFLOW_ERR;

  // Link-domain state
  logic lrst_meta_r, lrst_r;
  logic [1:0] pin_meta_r, pin_sync_r, pin_last_r;
  logic [CFG_W-1:0] cfg_meta_r, cfg_s_r;
  link_state_e st_r, st_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, byte_r;
  logic [1:0] ack_step_r, ack_step_nxt;
  logic nack_r, forced_nack_r, is_read_r, zero_at_byte_r;
  logic hold_r, hold_seen_r, scl_drv_r, sda_drv_r, hold_req;
  logic [`EV_NUM-1:0] ev_l;

  // Quasi-static settings cross as levels; software changes them only while the link waits
  wire [CFG_W-1:0] cfg_m = {CTRL, HIGH_ADDR_MATCH_A, HIGH_ADDR_MATCH_B, LOW_ADDR_MATCH_A,
                            LOW_ADDR_MATCH_B, err_any, stretch_r, rx_full_r, cnt_zero};
  ctrl_s ctrl_l;
  assign ctrl_l = cfg_s_r[41:36];
  wire [7:0] hi_a_l = cfg_s_r[35:28];
  wire [7:0] hi_b_l = cfg_s_r[27:20];
  wire [7:0] lo_a_l = cfg_s_r[19:12];
  wire [7:0] lo_b_l = cfg_s_r[11:4];
  wire err_l = cfg_s_r[3];
  wire stretch_l = cfg_s_r[2];
  wire full_l = cfg_s_r[1];
  wire zero_l = cfg_s_r[0];

  always_ff @(posedge LCLK) begin
    lrst_meta_r <= SRST;
    lrst_r <= lrst_meta_r;
    pin_meta_r <= {SCL_I, SDA_I};
    pin_sync_r <= pin_meta_r;
    pin_last_r <= pin_sync_r;
    cfg_meta_r <= cfg_m;
    cfg_s_r <= cfg_meta_r;
  end

  // Bus conditions, all seen through the synchronisers
  wire scl_s = pin_sync_r[1];
  wire sda_s = pin_sync_r[0];
  wire scl_d = pin_last_r[1];
  wire sda_d = pin_last_r[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & ~sda_s & sda_d;
  wire stop_c = scl_s & scl_d & sda_s & ~sda_d;

  wire in_byte = (st_r == L_HI) || (st_r == L_LO) || (st_r == L_DATA);
  wire in_ack = (st_r == L_HI_ACK) || (st_r == L_LO_ACK) || (st_r == L_DATA_ACK);
  wire [7:0] next_byte = {shift_r[6:0], sda_s};
  wire byte_done = in_byte & scl_rise & (bit_cnt_r == `LAST_BIT);
  wire hi_hit = addr_hit(next_byte, hi_a_l, hi_b_l, 1'b0);
  wire lo_hit = addr_hit(next_byte, lo_a_l, lo_b_l, 1'b1);
  wire ack_end = in_ack & scl_fall & (ack_step_r == `ACK_PULSE);

  // Acknowledge level, 1 means NACK; software may change it while the clock is held
  wire ack_bit = (st_r == L_HI_ACK) ? (forced_nack_r | ctrl_l.ack_value) :
                 (st_r == L_DATA_ACK) ?
                 (zero_at_byte_r ? ctrl_l.count_end_ack_value : ctrl_l.ack_value) :
                 ctrl_l.ack_value;
  wire data_wait = (st_r == L_DATA) & (bit_cnt_r == `WAIT_BIT) & full_l;
  wire want_hold = hold_r | data_wait;

  always_comb begin
    st_nxt = st_r;
    ev_l = '0;
    hold_req = 1'b0;
    if (start_c) begin
      st_nxt = L_HI;
      ev_l[`EV_START] = 1'b1;
    end else if (stop_c) begin
      st_nxt = L_IDLE;
      ev_l[`EV_STOP] = 1'b1;
    end else begin
      case (st_r)
        L_IDLE: begin
          st_nxt = L_IDLE;
        end
        L_HI: begin
          if (byte_done && hi_hit) begin
            st_nxt = L_HI_ACK;
            ev_l[`EV_HI_MATCH] = 1'b1;
            hold_req = ctrl_l.addr_hold_irq_enable;
          end else if (byte_done) begin
            st_nxt = L_IDLE;
            ev_l[`EV_MISS] = 1'b1;
          end
        end
        L_LO: begin
          if (byte_done && lo_hit) begin
            st_nxt = L_LO_ACK;
            ev_l[`EV_LO_MATCH] = 1'b1;
            hold_req = ctrl_l.addr_hold_irq_enable;
          end else if (byte_done) begin
            st_nxt = L_IDLE;
            ev_l[`EV_MISS] = 1'b1;
          end
        end
        L_DATA: begin
          if (byte_done) begin
            st_nxt = L_DATA_ACK;
            ev_l[`EV_DATA] = 1'b1;
            hold_req = ctrl_l.write_hold_irq_enable;
          end
        end
        L_HI_ACK: begin
          if (ack_end && (forced_nack_r || nack_r)) begin
            st_nxt = L_IDLE;
            ev_l[`EV_MISS] = 1'b1;
          end else if (ack_end && is_read_r) begin
            st_nxt = L_IDLE;
          end else if (ack_end) begin
            st_nxt = L_LO;
            hold_req = ctrl_l.ack_hold_irq_enable;
          end
        end
        L_LO_ACK: begin
          if (ack_end && nack_r) begin
            st_nxt = L_IDLE;
            ev_l[`EV_MISS] = 1'b1;
          end else if (ack_end) begin
            st_nxt = L_DATA;
            hold_req = ctrl_l.ack_hold_irq_enable;
          end
        end
        L_DATA_ACK: begin
          if (ack_end) begin
            ev_l[`EV_ACK_DONE] = 1'b1;
            ev_l[`EV_NACK] = nack_r;
            st_nxt = nack_r ? L_IDLE : L_DATA;
            hold_req = ~nack_r & ctrl_l.ack_hold_irq_enable;
          end
        end
        default: begin
          st_nxt = L_IDLE;
        end
      endcase
    end
    ev_l[`EV_HOLD] = hold_req;
  end

  assign bit_cnt_nxt = (start_c || st_nxt != st_r) ? `BIT_CNT_RESET :
                       (in_byte && scl_rise) ? 4'(bit_cnt_r + 4'h1) : bit_cnt_r;
  assign ack_step_nxt = (st_nxt != st_r) ? `ACK_WAIT :
                        (in_ack && scl_fall && ack_step_r == `ACK_WAIT) ? `ACK_DRIVE :
                        (in_ack && scl_rise && ack_step_r == `ACK_DRIVE) ? `ACK_PULSE :
                        ack_step_r;
  wire nack_take = in_ack & scl_rise & (ack_step_r == `ACK_DRIVE);
  wire hi_take = (st_r == L_HI) & byte_done;
  // Hold ends once the stretch bit was seen set and then cleared by software, or on a start or stop condition
  wire hold_nxt = hold_req | (hold_r & ~(hold_seen_r & ~stretch_l) & ~start_c & ~stop_c);
  wire hold_seen_nxt = ~hold_req & hold_nxt & (hold_seen_r | stretch_l);
  // SCL is only pulled once the master has driven it low, so no early edge is made
  wire scl_drv_nxt = want_hold & (~scl_s | scl_drv_r);
  wire sda_drv_nxt = in_ack & (ack_step_r != `ACK_WAIT) & ~ack_bit;

  always_ff @(posedge LCLK) begin
    if (lrst_r) begin
      st_r <= L_IDLE;
      bit_cnt_r <= `BIT_CNT_RESET;
      shift_r <= `BYTE_RESET;
      byte_r <= `BYTE_RESET;
      ack_step_r <= `ACK_WAIT;
      {nack_r, forced_nack_r, is_read_r, zero_at_byte_r} <= 4'h0;
      {hold_r, hold_seen_r, scl_drv_r, sda_drv_r} <= 4'h0;
    end else begin
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= (in_byte && scl_rise) ? next_byte : shift_r;
      byte_r <= byte_done ? next_byte : byte_r;
      ack_step_r <= ack_step_nxt;
      nack_r <= nack_take ? sda_s : nack_r;
      forced_nack_r <= hi_take ? err_l : forced_nack_r;
      is_read_r <= hi_take ? next_byte[`DIR_BIT] : is_read_r;
      zero_at_byte_r <= ((st_r == L_DATA) && byte_done) ? zero_l : zero_at_byte_r;
      hold_r <= hold_nxt;
      hold_seen_r <= hold_seen_nxt;
      scl_drv_r <= scl_drv_nxt;
      sda_drv_r <= sda_drv_nxt;
    end
  end

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = ~scl_drv_r;
  assign SDA_OE_N = ~sda_drv_r;

  event_cross #(.N(`EV_NUM)) u_ev (
    .src_clk(LCLK),
    .src_rst(lrst_r),
    .src_pulse(ev_l),
    .dst_clk(MCLK),
    .dst_rst(SRST),
    .dst_pulse(ev_m)
  );

  // System side: byte_r is held for a whole byte time, so reading it on the event is safe
  assign flag_set = {(ev_m[`EV_START] & CTRL.start_irq_enable) | ev_m[`EV_HOLD],
                     ev_m[`EV_NACK],
                     ev_m[`EV_ACK_DONE] & cnt_zero,
                     ev_m[`EV_DATA],
                     ev_m[`EV_LO_MATCH],
                     ev_m[`EV_STOP],
                     ev_m[`EV_START]};
  assign flags_nxt = (flags_r & ~FLAG_CLR) | flag_set;
  assign cnt_nxt = BYTE_COUNT_LOAD ? BYTE_COUNT_IN :
                   (ev_m[`EV_DATA] && !cnt_zero) ? 8'(cnt_r - 8'h01) : cnt_r;
  wire addr_ev = ev_m[`EV_HI_MATCH] | ev_m[`EV_LO_MATCH];

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      flags_r <= '0;
      {stretch_r, rx_full_r, active_r, dir_r, dna_r} <= 5'h00;
      rx_buf_r <= `BYTE_RESET;
      hi_cap_r <= `BYTE_RESET;
      lo_cap_r <= `BYTE_RESET;
      cnt_r <= `CNT_ZERO;
    end else begin
      flags_r <= flags_nxt;
      stretch_r <= (stretch_r & ~CLOCK_STRETCH_CLR) | ev_m[`EV_HOLD];
      rx_full_r <= (rx_full_r & ~RX_READ) | ev_m[`EV_DATA];
      active_r <= ev_m[`EV_LO_MATCH] |
                  (active_r & ~ev_m[`EV_STOP] & ~ev_m[`EV_MISS]);
      // Only the high byte carries a direction bit; a low match keeps it
      dir_r <= ev_m[`EV_HI_MATCH] ? byte_r[`DIR_BIT] : dir_r;
      dna_r <= ev_m[`EV_DATA] | (dna_r & ~addr_ev);
      rx_buf_r <= ev_m[`EV_DATA] ? byte_r : rx_buf_r;
      hi_cap_r <= ev_m[`EV_HI_MATCH] ? byte_r : hi_cap_r;
      lo_cap_r <= ev_m[`EV_LO_MATCH] ? byte_r : lo_cap_r;
      cnt_r <= cnt_nxt;
    end
  end

  assign FLAGS = flags_r;
  assign CLOCK_STRETCH_BIT = stretch_r;
  assign TARGET_ACTIVE = active_r;
  assign RX_BUFFER_FULL = rx_full_r;
  assign RX_BUFFER = rx_buf_r;
  assign HIGH_ADDR_CAPTURE = hi_cap_r;
  assign LOW_ADDR_CAPTURE = lo_cap_r;
  assign BYTE_COUNTER = cnt_r;
  assign DIRECTION = dir_r;
  assign DATA_NOT_ADDR = dna_r;

  a_start_to_high: assert property (@(posedge LCLK) disable iff (lrst_r)
    start_c |=> (st_r == L_HI) && (bit_cnt_r == `BIT_CNT_RESET))
    else $error("start did not open high address byte");
  a_high_miss_idle: assert property (@(posedge LCLK) disable iff (lrst_r)
    (st_r == L_HI) && byte_done && !hi_hit && !start_c && !stop_c |=> st_r == L_IDLE)
    else $error("high address mismatch did not go idle");
  a_low_compare: assert property (@(posedge LCLK) disable iff (lrst_r)
    (st_r == L_LO) && byte_done && lo_hit && !start_c && !stop_c |=> st_r == L_LO_ACK)
    else $error("low address match not acknowledged");
  a_hold_pulls_scl: assert property (@(posedge LCLK) disable iff (lrst_r)
    hold_r && !scl_s |=> !SCL_OE_N)
    else $error("clock not stretched while held");
  a_data_wait: assert property (@(posedge LCLK) disable iff (lrst_r)
    data_wait && !scl_s |=> !SCL_OE_N)
    else $error("full buffer did not stretch clock");
  a_error_nack: assert property (@(posedge LCLK) disable iff (lrst_r)
    (st_r == L_HI_ACK) && forced_nack_r |=> SDA_OE_N)
    else $error("pending error did not force NACK");
  a_ack_drive: assert property (@(posedge LCLK) disable iff (lrst_r)
    in_ack && (ack_step_r == `ACK_DRIVE) && !ack_bit |=> !SDA_OE_N)
    else $error("acknowledge not driven");
  a_stop_idle: assert property (@(posedge LCLK) disable iff (lrst_r)
    stop_c && !start_c |=> st_r == L_IDLE)
    else $error("stop did not go idle");
  a_nack_idle: assert property (@(posedge LCLK) disable iff (lrst_r)
    ack_end && (st_r == L_DATA_ACK) && nack_r && !start_c && !stop_c |=> st_r == L_IDLE)
    else $error("data NACK did not go idle");
  a_data_loop: assert property (@(posedge LCLK) disable iff (lrst_r)
    ack_end && (st_r == L_DATA_ACK) && !nack_r && !start_c && !stop_c |=> st_r == L_DATA)
    else $error("good data ack did not return to data");
  a_low_active: assert property (@(posedge MCLK) disable iff (SRST)
    ev_m[`EV_LO_MATCH] |=> TARGET_ACTIVE && FLAGS.addr_match_flag && !DATA_NOT_ADDR)
    else $error("low match status not set");
  a_rx_load: assert property (@(posedge MCLK) disable iff (SRST)
    ev_m[`EV_DATA] |=> RX_BUFFER_FULL && FLAGS.write_received_flag && DATA_NOT_ADDR
                       && (RX_BUFFER == $past(byte_r)))
    else $error("data byte not loaded");
  a_count_dec: assert property (@(posedge MCLK) disable iff (SRST)
    ev_m[`EV_DATA] && !BYTE_COUNT_LOAD && !cnt_zero |=> BYTE_COUNTER == $past(cnt_r) - 8'h01)
    else $error("byte counter not decremented");
  a_count_flag: assert property (@(posedge MCLK) disable iff (SRST)
    ev_m[`EV_ACK_DONE] && cnt_zero |=> FLAGS.count_reached_flag)
    else $error("count reached flag not set");
  a_start_irq: assert property (@(posedge MCLK) disable iff (SRST)
    ev_m[`EV_START] && CTRL.start_irq_enable |=> FLAGS.shared_irq_flag && FLAGS.start_seen_flag)
    else $error("start interrupt flag not set");

  c_address_pair: cover property (@(posedge LCLK) disable iff (lrst_r)
    (st_r == L_LO_ACK) ##[1:1000] (st_r == L_DATA));
  c_data_nack: cover property (@(posedge LCLK) disable iff (lrst_r)
    ack_end && (st_r == L_DATA_ACK) && nack_r);
  c_stretch: cover property (@(posedge LCLK) disable iff (lrst_r)
    hold_r && !SCL_OE_N);
  c_full_wait: cover property (@(posedge LCLK) disable iff (lrst_r) data_wait);

endmodule : i2c_rx10_target

/* File: verification/i2c_master_model.sv */
// Behavioural I2C bus master that drives the target through open-drain wires
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  localparam int HALF = 200;
  // Count of releases that never saw SCL high; the bench expects none
  int stalls = 0;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Release SCL and wait out a stretch by the target, bounded so a stuck bus cannot hang
  task automatic rise();
    int n = 0;
    scl_out = 1'b1;
    while (scl_in !== 1'b1 && n < 20000) begin
      #10;
      n++;
    end
    if (n >= 20000) stalls++;
    #HALF;
  endtask : rise
  // Serves for start and repeated start; every transfer opens here
  task automatic start();
    #40;
    sda_out = 1'b1;
    #HALF;
    rise();
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    #40;
    sda_out = 1'b0;
    #HALF;
    rise();
    sda_out = 1'b1;
    #(2 * HALF);
  endtask : stop
  // SDA moves only after a short hold past the SCL fall, never while SCL is high
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40;
      sda_out = b[i];
      #HALF;
      rise();
      scl_out = 1'b0;
    end
    #40;
    sda_out = 1'b1;
    #HALF;
    rise();
    ack = sda_in;
    scl_out = 1'b0;
  endtask : xfer
endmodule : i2c_master_model

/* File: verification/test_i2c_rx10_target.sv */
// Self-checking bench for the ten-bit address I2C target receiver
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); end end
module test_i2c_rx10_target;
  import i2c_rx10_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, lclk = 1'b0;
  logic rx_ovf = 1'b0, tx_unf = 1'b0, cs_clr = 1'b0, rx_rd = 1'b0, cnt_ld = 1'b0;
  logic [7:0] ha_a = 8'hf2, ha_b = 8'hf6, la_a = 8'h3c, la_b = 8'ha5, cnt_in = 8'h00;
  ctrl_s ctrl = '0;
  flags_s fclr = '0;
  flags_s flags;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, stretch, active, rxf, dir, dna, ack;
  logic [7:0] rxb, hcap, lcap, bcnt;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  // Open-drain wires with pull-ups
  wire scl = m_scl & (scl_oe_n | scl_o);
  wire sda = m_sda & (sda_oe_n | sda_o);
  always #12.5 mclk = ~mclk;
  initial begin
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  i2c_rx10_target i_dut (.MCLK(mclk), .SRST(srst), .LCLK(lclk), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .HIGH_ADDR_MATCH_A(ha_a), .HIGH_ADDR_MATCH_B(ha_b), .LOW_ADDR_MATCH_A(la_a),
    .LOW_ADDR_MATCH_B(la_b), .CTRL(ctrl), .RX_OVERFLOW_ERR(rx_ovf), .TX_UNDERFLOW_ERR(tx_unf),
    .CLOCK_STRETCH_CLR(cs_clr), .RX_READ(rx_rd), .FLAG_CLR(fclr), .BYTE_COUNT_LOAD(cnt_ld),
    .BYTE_COUNT_IN(cnt_in), .FLAGS(flags), .CLOCK_STRETCH_BIT(stretch), .TARGET_ACTIVE(active),
    .RX_BUFFER_FULL(rxf), .RX_BUFFER(rxb), .HIGH_ADDR_CAPTURE(hcap), .LOW_ADDR_CAPTURE(lcap),
    .BYTE_COUNTER(bcnt), .DIRECTION(dir), .DATA_NOT_ADDR(dna));
  i2c_master_model i_master (.scl_in(scl), .sda_in(sda), .scl_out(m_scl), .sda_out(m_sda));
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic settle();
    repeat (20) @(negedge mclk);
  endtask : settle
  // One-cycle software pulses: flag clear mask, buffer read, stretch clear, count load
  task automatic sw(input logic [6:0] c, input logic rd, cs, ld, input logic [7:0] v);
    @(negedge mclk);
    fclr = c;
    rx_rd = rd;
    cs_clr = cs;
    cnt_ld = ld;
    cnt_in = v;
    @(negedge mclk);
    fclr = '0;
    rx_rd = 1'b0;
    cs_clr = 1'b0;
    cnt_ld = 1'b0;
  endtask : sw
  // Byte during which, or after whose acknowledge, the target stretches until cleared
  task automatic held(input logic [7:0] b);
    sw(7'h40, 1'b0, 1'b0, 1'b0, 8'h00);
    fork
      i_master.xfer(b, ack);
      begin
        for (int i = 0; i < 4000 && stretch !== 1'b1; i++) @(negedge mclk);
        repeat (20) @(negedge mclk);
        `CHK({scl_oe_n, stretch}, 2'b01)
        `CHK(flags.shared_irq_flag, 1'b1)
        sw(7'h00, 1'b0, 1'b1, 1'b0, 8'h00);
        `CHK(stretch, 1'b0)
      end
    join
    `CHK(ack, 1'b0)
  endtask : held
  task automatic t_reset();
    `CHK(flags, 7'h00)
    `CHK({stretch, active, rxf, scl_oe_n, sda_oe_n}, 5'h03)
    `CHK({scl_o, sda_o}, 2'b00)
  endtask : t_reset
  task automatic t_write();
    @(negedge mclk);
    ctrl.count_end_ack_value = 1'b1;
    sw(7'h7f, 1'b1, 1'b0, 1'b1, 8'h01);
    i_master.start();
    i_master.xfer(8'hf6, ack);
    `CHK(ack, 1'b0)
    `CHK(hcap, 8'hf6)
    `CHK({dir, dna}, 2'b00)
    `CHK(active, 1'b0)
    `CHK(flags.start_seen_flag, 1'b1)
    i_master.xfer(8'ha5, ack);
    `CHK(ack, 1'b0)
    `CHK(lcap, 8'ha5)
    `CHK({active, flags.addr_match_flag, dir, dna}, 4'b1100)
    i_master.xfer(8'h5a, ack);
    settle();
    `CHK(ack, 1'b0)
    `CHK(rxb, 8'h5a)
    `CHK({rxf, dna, flags.write_received_flag}, 3'b111)
    `CHK(bcnt, 8'h00)
    `CHK(flags.count_reached_flag, 1'b1)
    sw(7'h00, 1'b1, 1'b0, 1'b0, 8'h00);
    `CHK(rxf, 1'b0)
    i_master.xfer(8'hc3, ack);
    settle();
    `CHK(ack, 1'b1)
    `CHK(flags.nack_flag, 1'b1)
    // Read request: repeated start and the high byte with the direction bit set
    i_master.start();
    i_master.xfer(8'hf7, ack);
    `CHK(ack, 1'b0)
    `CHK({dir, active, hcap}, {2'b11, 8'hf7})
    i_master.stop();
    settle();
    `CHK({flags.stop_seen_flag, active}, 2'b10)
    ctrl.count_end_ack_value = 1'b0;
  endtask : t_write
  task automatic t_miss();
    sw(7'h7f, 1'b1, 1'b0, 1'b0, 8'h00);
    i_master.start();
    i_master.xfer(8'hf4, ack);
    `CHK(ack, 1'b1)
    i_master.stop();
    // No prefix format is enforced on the high match value
    @(negedge mclk);
    ha_a = 8'h0a;
    i_master.start();
    i_master.xfer(8'h0a, ack);
    `CHK(ack, 1'b0)
    i_master.xfer(8'h3d, ack);
    `CHK(ack, 1'b1)
    `CHK({active, flags.addr_match_flag}, 2'b00)
    i_master.stop();
    @(negedge mclk);
    ha_a = 8'hf2;
  endtask : t_miss
  task automatic t_err();
    for (int e = 0; e < 2; e++) begin
      @(negedge mclk);
      rx_ovf = (e == 0);
      tx_unf = (e == 1);
      i_master.start();
      i_master.xfer(8'hf2, ack);
      `CHK(ack, 1'b1)
      i_master.stop();
    end
    @(negedge mclk);
    rx_ovf = 1'b0;
    tx_unf = 1'b0;
  endtask : t_err
  task automatic t_hold();
    @(negedge mclk);
    ctrl = 6'h30;
    sw(7'h7f, 1'b1, 1'b0, 1'b1, 8'h00);
    i_master.start();
    settle();
    `CHK(flags.shared_irq_flag, 1'b1)
    held(8'hf2);
    held(8'h3c);
    @(negedge mclk);
    ctrl = 6'h04;
    held(8'h77);
    `CHK(rxb, 8'h77)
    // Let the acknowledge end pass before the hold enables change
    settle();
    ctrl = 6'h08;
    sw(7'h00, 1'b1, 1'b0, 1'b0, 8'h00);
    held(8'h66);
    `CHK(rxb, 8'h66)
    @(negedge mclk);
    ctrl = 6'h00;
    // Buffer left unread: the next byte must wait until software reads it
    fork
      i_master.xfer(8'h99, ack);
      begin
        repeat (300) @(negedge mclk);
        `CHK({scl_oe_n, rxb}, {1'b0, 8'h66})
        sw(7'h00, 1'b1, 1'b0, 1'b0, 8'h00);
      end
    join
    `CHK({ack, rxb}, {1'b0, 8'h99})
    i_master.stop();
    `CHK(i_master.stalls, 0)
  endtask : t_hold
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    t_reset();
    t_write();
    t_miss();
    t_err();
    t_hold();
    wrap_up();
  end
endmodule : test_i2c_rx10_target
